// ### core/duty_engine.sv
// One generator: pre-divider, 16-bit down counter, ON/OFF state.
// Assumes settings from the bank, all on clk.
`timescale 1ns/10ps
`default_nettype none

module duty_engine (
  input wire logic clk,
  input wire logic rst,
  engine_if.engine link
);
  import pwm_pkg::*;

  engine_state_t s_q;
  engine_state_t s_d;
  logic src;
  logic tick;

  always_comb begin
    s_d = s_q;
    s_d.off_done = 1'b0;
    tick = 1'b0;
    src = link.clk_sel ? link.slow_tick : 1'b1;
    if (!link.enable || link.sleep) begin
      // Clean restart on re-enable or wake
      s_d.st = GEN_OFF;
      s_d.cnt = 16'h0000;
      s_d.div = 4'h0;
    end else begin
      if (src) begin
        if (s_q.div == link.prediv) begin
          s_d.div = 4'h0;
          tick = 1'b1;
        end else begin
          s_d.div = s_q.div + 4'h1;
        end
      end
      if (link.off_count == 16'h0000) begin
        s_d.st = GEN_ON;
        s_d.cnt = 16'h0000;
      end else if (link.on_count == 16'h0000) begin
        s_d.st = GEN_OFF;
        s_d.cnt = 16'h0000;
      end else if (tick) begin
        if (s_q.cnt != 16'h0000) begin
          s_d.cnt = s_q.cnt - 16'h0001;
        end else begin
          case (s_q.st)
            GEN_OFF: begin
              s_d.cnt = link.on_count;
              s_d.st = GEN_ON;
              s_d.off_done = 1'b1;
            end
            GEN_ON: begin
              s_d.cnt = link.off_count;
              s_d.st = GEN_OFF;
            end
            default: begin
              s_d.st = GEN_OFF;
            end
          endcase
        end
      end
    end
    s_d.level = (s_d.st == GEN_ON) ^ link.invert;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q.st <= GEN_OFF;
      s_q.cnt <= 16'h0000;
      s_q.div <= 4'h0;
      s_q.level <= 1'b0;
      s_q.off_done <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign link.level = s_q.level;
  assign link.off_done = s_q.off_done;

endmodule

`default_nettype wire

// ### core/engine_if.sv
// Link between the register bank and one counting engine.
// Both ends run on the same clock.
`timescale 1ns/10ps
`default_nettype none

interface engine_if;
  logic enable;
  logic clk_sel;
  logic invert;
  logic sleep;
  logic slow_tick;
  logic [3:0] prediv;
  logic [15:0] on_count;
  logic [15:0] off_count;
  logic level;
  logic off_done;

  modport bank (
    output enable, clk_sel, invert, sleep, slow_tick, prediv,
    output on_count, off_count,
    input level, off_done
  );
  modport engine (
    input enable, clk_sel, invert, sleep, slow_tick, prediv,
    input on_count, off_count,
    output level, off_done
  );
endinterface

`default_nettype wire

// ### core/pwm_bank.sv
// Bank of eight duty cycle generators with their register file.
// Assumes a simple word bus on clk and sleep requests from elsewhere.
//
// Function
// - OFF count zero: output held fully on
// - ON zero, OFF nonzero: output fully off
// - Both nonzero: toggle with ON/OFF durations
// - Counts preload one 16-bit down counter
// - OFF and zero: load ON, go ON
// - ON and zero: load OFF, go OFF
// - Count writes land in holding registers
// - Transfer after four bytes and OFF end
// - Full on: transfer once four bytes written
// - Holding marked empty after each transfer
// - Reads return active counts, not holding
// - Disabled: counters reset, output inactive
// - Count registers unaffected by enable bit
// - Clock select: fast clock or slow enable
// - Invert bit chooses ON output level
// - Tick rate is source over divider plus one
// - Reset: ON 0000, OFF FFFF, full off
// - Eight instances, 80h apart from base
// - Pre-divider occupies config bits six to three
// - Sleep resets counters; request is inverse
// - System reset: output off, counts default
`timescale 1ns/10ps
`default_nettype none
`include "pwm_defs.svh"

module pwm_bank (
  input wire logic clk,
  input wire logic rst,
  input wire logic [23:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [1:0] bus_be,
  input wire logic [15:0] bus_wdata,
  output logic [15:0] bus_rdata,
  output logic bus_rvalid,
  input wire logic [7:0] sleep_request,
  output logic [7:0] clock_request,
  output logic [7:0] pwm_out
);
  import pwm_pkg::*;

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  localparam logic [23:0] BASE = `GEN_BASE_ADDR;

  function automatic logic reg_hit(
    input logic [23:0] addr,
    input logic [2:0] inst,
    input logic [6:0] ofs
  );
    reg_hit = (addr[23:10] == BASE[23:10]) &&
              (addr[9:`GEN_STRIDE_SHIFT] == inst) &&
              (addr[6:0] == ofs);
  endfunction

  function automatic logic [15:0] merge16(
    input logic [15:0] old,
    input logic [15:0] nw,
    input logic [1:0] be
  );
    merge16 = {be[1] ? nw[15:8] : old[15:8],
               be[0] ? nw[7:0] : old[7:0]};
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  bank_state_t s_q;
  bank_state_t s_d;
  logic [7:0] off_done_w;
  logic [7:0] level_w;
  logic [2:0] rd_inst;
  logic [15:0] rd_val;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.rvalid = 1'b0;
    rd_inst = bus_addr[9:`GEN_STRIDE_SHIFT];
    rd_val = 16'h0000;

    // Sleep pins cross in through two stages
    s_d.sleep_meta = sleep_request;
    s_d.sleep_sync = s_q.sleep_meta;
    s_d.clk_req = ~s_q.sleep_sync;

    // Shared slow enable, one pulse per slow period
    s_d.slow_tick = 1'b0;
    if (s_q.slow_cnt == 11'(`SLOW_CYCLES - 1)) begin
      s_d.slow_cnt = 11'h000;
      s_d.slow_tick = 1'b1;
    end else begin
      s_d.slow_cnt = s_q.slow_cnt + 11'h001;
    end

    for (int i = 0; i < `GEN_COUNT; i++) begin
      // Transfer; also in full off or disabled, else new counts never land
      if (s_q.fresh[i] == 4'hF &&
          (off_done_w[i] ||
           s_q.off_count[i] == 16'h0000 ||
           s_q.on_count[i] == 16'h0000 ||
           !s_q.generator_config[i][`CFG_ENABLE_BIT])) begin
        s_d.on_count[i] = s_q.hold_on[i];
        s_d.off_count[i] = s_q.hold_off[i];
        s_d.fresh[i] = 4'h0;
      end
      // A byte written in the transfer cycle stays pending
      if (bus_wr && reg_hit(bus_addr, 3'(i), `ON_COUNT_OFS)) begin
        s_d.hold_on[i] = merge16(s_q.hold_on[i], bus_wdata, bus_be);
        s_d.fresh[i][1:0] = s_d.fresh[i][1:0] | bus_be;
      end
      if (bus_wr && reg_hit(bus_addr, 3'(i), `OFF_COUNT_OFS)) begin
        s_d.hold_off[i] = merge16(s_q.hold_off[i], bus_wdata, bus_be);
        s_d.fresh[i][3:2] = s_d.fresh[i][3:2] | bus_be;
      end
      if (bus_wr && bus_be[0] &&
          reg_hit(bus_addr, 3'(i), `GEN_CONFIG_OFS)) begin
        s_d.generator_config[i] = bus_wdata[6:0];
      end
    end

    // Reads: active counts only, reserved bits zero
    if (bus_rd) begin
      if (reg_hit(bus_addr, rd_inst, `ON_COUNT_OFS)) begin
        rd_val = s_q.on_count[rd_inst];
      end else if (reg_hit(bus_addr, rd_inst, `OFF_COUNT_OFS)) begin
        rd_val = s_q.off_count[rd_inst];
      end else if (reg_hit(bus_addr, rd_inst, `GEN_CONFIG_OFS)) begin
        rd_val = {9'h000, s_q.generator_config[rd_inst]};
      end else begin
        rd_val = 16'h0000;
      end
      s_d.rdata = rd_val;
      s_d.rvalid = 1'b1;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < `GEN_COUNT; i++) begin
        s_q.on_count[i] <= `ON_COUNT_RESET;
        s_q.off_count[i] <= `OFF_COUNT_RESET;
        s_q.hold_on[i] <= `ON_COUNT_RESET;
        s_q.hold_off[i] <= `OFF_COUNT_RESET;
        s_q.fresh[i] <= 4'h0;
        s_q.generator_config[i] <= `GEN_CONFIG_RESET;
      end
      s_q.sleep_meta <= 8'h00;
      s_q.sleep_sync <= 8'h00;
      s_q.clk_req <= 8'hFF;
      s_q.slow_cnt <= 11'h000;
      s_q.slow_tick <= 1'b0;
      s_q.rdata <= 16'h0000;
      s_q.rvalid <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Engines
  // ----------------------------------------
  for (genvar g = 0; g < `GEN_COUNT; g++) begin : gen_inst
    engine_if link ();
    assign link.enable = s_q.generator_config[g][`CFG_ENABLE_BIT];
    assign link.clk_sel = s_q.generator_config[g][`CFG_CLK_SEL_BIT];
    assign link.invert = s_q.generator_config[g][`CFG_INVERT_BIT];
    assign link.prediv =
      s_q.generator_config[g][`CFG_PREDIV_MSB:`CFG_PREDIV_LSB];
    assign link.sleep = s_q.sleep_sync[g];
    assign link.slow_tick = s_q.slow_tick;
    assign link.on_count = s_q.on_count[g];
    assign link.off_count = s_q.off_count[g];
    assign off_done_w[g] = link.off_done;
    assign level_w[g] = link.level;

    duty_engine u_engine (
      .clk(clk),
      .rst(rst),
      .link(link.engine)
    );
  end

  // ----------------------------------------
  // Outputs, all from flip-flops
  // ----------------------------------------
  assign bus_rdata = s_q.rdata;
  assign bus_rvalid = s_q.rvalid;
  assign clock_request = s_q.clk_req;
  assign pwm_out = level_w;

endmodule

`default_nettype wire

// ### core/pwm_defs.svh
// Register map, field positions, reset values and timing counts
// for the duty cycle generator bank. Definitions only.
`ifndef PWM_DEFS_SVH
`define PWM_DEFS_SVH

// ----------------------------------------
// Addressing
// ----------------------------------------
`define GEN_BASE_ADDR 24'hF05800
`define GEN_STRIDE_SHIFT 7
`define GEN_COUNT 8
`define ON_COUNT_OFS 7'h00
`define OFF_COUNT_OFS 7'h04
`define GEN_CONFIG_OFS 7'h08

// ----------------------------------------
// Configuration fields
// ----------------------------------------
`define CFG_ENABLE_BIT 0
`define CFG_CLK_SEL_BIT 1
`define CFG_INVERT_BIT 2
`define CFG_PREDIV_LSB 3
`define CFG_PREDIV_MSB 6

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ON_COUNT_RESET 16'h0000
`define OFF_COUNT_RESET 16'hFFFF
`define GEN_CONFIG_RESET 7'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 8
`define SLOW_PERIOD_NS 10000
`define SLOW_CYCLES (`SLOW_PERIOD_NS / `CLK_PERIOD_NS)

`endif

// ### core/pwm_pkg.sv
// Types shared by the generator bank and its engines.
// Widths follow the constants header.
`default_nettype none

package pwm_pkg;

  typedef enum logic [1:0] {
    GEN_OFF = 2'b01,
    GEN_ON = 2'b10
  } gen_state_t;

  typedef struct packed {
    gen_state_t st;
    logic [15:0] cnt;
    logic [3:0] div;
    logic level;
    logic off_done;
  } engine_state_t;

  typedef struct packed {
    logic [7:0][15:0] on_count;
    logic [7:0][15:0] off_count;
    logic [7:0][15:0] hold_on;
    logic [7:0][15:0] hold_off;
    logic [7:0][3:0] fresh;
    logic [7:0][6:0] generator_config;
    logic [7:0] sleep_meta;
    logic [7:0] sleep_sync;
    logic [7:0] clk_req;
    logic [10:0] slow_cnt;
    logic slow_tick;
    logic [15:0] rdata;
    logic rvalid;
  } bank_state_t;

endpackage

`default_nettype wire

// ### verification/pwm_bank_props.sv
// Port checker for the generator bank.
// Assumes one clock and a synchronous active high reset.
`timescale 1ns/10ps
`default_nettype none

module pwm_bank_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic [23:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [1:0] bus_be,
  input wire logic [15:0] bus_wdata,
  input wire logic [15:0] bus_rdata,
  input wire logic bus_rvalid,
  input wire logic [7:0] sleep_request,
  input wire logic [7:0] clock_request,
  input wire logic [7:0] pwm_out
);
  // ----------------------------------------
  // Shadow of instance 0 config, byte 0 only
  // ----------------------------------------
  logic [6:0] cfg_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_q <= 7'h00;
    end else if (bus_wr && bus_be[0] && bus_addr == 24'hF05808) begin
      cfg_q <= bus_wdata[6:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_read_answer: assert property (bus_rd |=> bus_rvalid)
    else $error("read got no answer");
  a_answer_cause: assert property (bus_rvalid |-> $past(bus_rd))
    else $error("answer without read");
  a_rdata_holds: assert property (!$past(rst) && !$past(bus_rd)
    |-> $stable(bus_rdata)) else $error("read data moved");
  a_clkreq_inverse: assert property ($stable(sleep_request) [*4]
    |-> clock_request == ~sleep_request) else $error("clock request");
  a_reset_state: assert property ($fell(rst) |-> pwm_out == 8'h00
    && !bus_rvalid && clock_request == 8'hFF) else $error("reset state");
  a_disabled_idle: assert property ((!cfg_q[0] && $stable(cfg_q)) [*3]
    |-> pwm_out[0] == cfg_q[2]) else $error("disabled level");
  a_sleep_idle: assert property ((sleep_request[0] && $stable(cfg_q)) [*6]
    |-> pwm_out[0] == cfg_q[2]) else $error("sleep level");
  a_unmapped_zero: assert property (bus_rd && bus_addr[23:10] != 14'h3C16
    |=> bus_rdata == 16'h0000) else $error("unmapped read");
  a_config_read: assert property (bus_rd && !bus_wr && bus_addr == 24'hF05808
    |=> bus_rdata == {9'h000, cfg_q}) else $error("config read");
  c_toggle: cover property ($rose(pwm_out[0]));
  c_sleep: cover property (sleep_request[0] && !clock_request[0]);
  c_read: cover property (bus_rvalid);
endmodule

bind pwm_bank pwm_bank_props props_u (.clk(clk), .rst(rst),
  .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_be(bus_be),
  .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
  .sleep_request(sleep_request), .clock_request(clock_request),
  .pwm_out(pwm_out));

`default_nettype wire

// ### verification/pwm_load.sv
// Load on one generator pin: measures high and low run lengths.
// Assumes the pin level changes only after clock edges.
`timescale 1ns/10ps
`default_nettype none

module pwm_load (
  input wire logic clk,
  input wire logic level,
  output logic [15:0] hi_len,
  output logic [15:0] lo_len
);
  logic [15:0] run_q = 16'h0000;
  logic last_q = 1'b0;
  initial begin
    hi_len = 16'h0000;
    lo_len = 16'h0000;
  end
  // Run length in clocks, latched when the level flips
  always @(posedge clk) begin
    if (level !== last_q) begin
      if (last_q) begin
        hi_len <= run_q;
      end else begin
        lo_len <= run_q;
      end
      run_q <= 16'h0001;
    end else begin
      run_q <= run_q + 16'h0001;
    end
    last_q <= level;
  end
endmodule

`default_nettype wire

// ### verification/testbench.sv
// Self-checking bench for the generator bank, instance 0 in depth.
// Assumes the simple word bus and reset timing of the bank.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_fail++; \
  $display("Error %0t: got %h want %h", $time, a, b); end end

module testbench;
  logic clk = 1'b0;
  logic rst, bus_wr, bus_rd, bus_rvalid;
  logic [23:0] bus_addr;
  logic [1:0] bus_be;
  logic [15:0] bus_wdata, bus_rdata, hi_len, lo_len, n, m, got;
  logic [7:0] sleep_request, clock_request, pwm_out;
  logic [15:0] exp_q[$];
  int n_fail = 0;
  int comparisons = 0;
  int seed;
  always #4 clk = ~clk;
  pwm_bank dut_u (.clk(clk), .rst(rst), .bus_addr(bus_addr),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_be(bus_be),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
    .sleep_request(sleep_request), .clock_request(clock_request),
    .pwm_out(pwm_out));
  pwm_load load_u (.clk(clk), .level(pwm_out[0]), .hi_len(hi_len),
    .lo_len(lo_len));
  // ----------------------------------------
  // Bus tasks and result watcher
  // ----------------------------------------
  task automatic wr(input logic [23:0] a, input logic [15:0] d,
                    input logic [1:0] be);
    @(negedge clk);
    bus_addr = a;
    bus_wdata = d;
    bus_be = be;
    bus_wr = 1'b1;
    @(negedge clk);
    bus_wr = 1'b0;
  endtask
  task automatic rd(input logic [23:0] a, input logic [15:0] e);
    @(negedge clk);
    bus_addr = a;
    bus_rd = 1'b1;
    exp_q.push_back(e);
    @(negedge clk);
    bus_rd = 1'b0;
  endtask
  // Three rises so a pending transfer has settled first
  task automatic measure(input logic [15:0] h, input logic [15:0] l);
    repeat (3) @(posedge pwm_out[0]);
    repeat (2) @(negedge clk);
    `CHK(hi_len, h)
    `CHK(lo_len, l)
  endtask
  always @(negedge clk) begin
    if (bus_rvalid === 1'b1) begin
      got = exp_q.pop_front();
      `CHK(bus_rdata, got)
    end
  end
  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #(8 * 30000);
    n_fail++;
    $display("Error %0t: watchdog expired", $time);
    end_sim;
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    seed = 32'h7d6c371f;
    rst = 1'b1;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_addr = 24'h000000;
    bus_be = 2'b00;
    bus_wdata = 16'h0000;
    sleep_request = 8'h00;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    for (int k = 0; k < 8; k++) begin
      rd({14'h3C16, 3'(k), 7'h00}, 16'h0000);
      rd({14'h3C16, 3'(k), 7'h04}, 16'hFFFF);
      rd({14'h3C16, 3'(k), 7'h08}, 16'h0000);
    end
    rd(24'hF05C00, 16'h0000);
    n = 16'(($random(seed) & 7) + 1);
    m = 16'(($random(seed) & 7) + 1);
    wr(24'hF05800, n, 2'b11);
    rd(24'hF05800, 16'h0000);
    wr(24'hF05804, m, 2'b11);
    rd(24'hF05800, n);
    wr(24'hF05808, 16'hFF09, 2'b11);
    rd(24'hF05808, 16'h0009);
    measure((n + 16'h0001) * 16'h0002, (m + 16'h0001) * 16'h0002);
    @(posedge pwm_out[0]);
    wr(24'hF05800, n + 16'h0001, 2'b11);
    wr(24'hF05804, m + 16'h0001, 2'b11);
    rd(24'hF05800, n);
    measure((n + 16'h0002) * 16'h0002, (m + 16'h0002) * 16'h0002);
    wr(24'hF05800, 16'h0009, 2'b01);
    measure((n + 16'h0002) * 16'h0002, (m + 16'h0002) * 16'h0002);
    wr(24'hF05800, 16'h0000, 2'b10);
    wr(24'hF05804, 16'h0000, 2'b11);
    repeat (60) @(negedge clk);
    `CHK(pwm_out[0], 1'b1)
    wr(24'hF05800, 16'h0000, 2'b11);
    wr(24'hF05804, 16'h0005, 2'b11);
    rd(24'hF05800, 16'h0000);
    `CHK(pwm_out[0], 1'b0)
    wr(24'hF05808, 16'h000D, 2'b11);
    repeat (5) @(negedge clk);
    `CHK(pwm_out[0], 1'b1)
    wr(24'hF05808, 16'h0004, 2'b11);
    wr(24'hF05800, 16'h0001, 2'b11);
    wr(24'hF05804, 16'h0001, 2'b11);
    wr(24'hF05808, 16'h0003, 2'b11);
    measure(16'h09C4, 16'h09C4);
    sleep_request = 8'($random(seed)) | 8'h01;
    repeat (8) @(negedge clk);
    `CHK(pwm_out[0], 1'b0)
    `CHK(clock_request, ~sleep_request)
    sleep_request = 8'h00;
    repeat (4) @(negedge clk);
    // Mid-run reset must bring counts back to defaults
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    rd(24'hF05800, 16'h0000);
    rd(24'hF05804, 16'hFFFF);
    `CHK(pwm_out, 8'h00)
    end_sim;
  end
endmodule

`default_nettype wire
